//--- logic/mpmb_regs.svh
// Offsets, field positions, codes and timing counts of the memory point mailbox.
// Assumes a 20 MHz clock and a register port with byte addresses.
`ifndef MPMB_REGS_SVH
`define MPMB_REGS_SVH

// Register offsets
`define MPMB_OFF_IFACE 8'h00
`define MPMB_OFF_LOW 8'h04
`define MPMB_OFF_HIGH 8'h08
`define MPMB_OFF_POINT 8'h0c

// Interface register fields
`define MPMB_IF_BUSY 31
`define MPMB_IF_P2_HI 23
`define MPMB_IF_P2_LO 16
`define MPMB_IF_P1_HI 15
`define MPMB_IF_P1_LO 8
`define MPMB_IF_CMD_HI 7
`define MPMB_IF_CMD_LO 0

// Commands and subcommands
`define MPMB_CMD_INFO 8'h0d
`define MPMB_CMD_RESTRICT 8'h0e
`define MPMB_CMD_LEGACY 8'h21
`define MPMB_SUB_GLOBAL 8'h00
`define MPMB_SUB_POINT 8'h01

// Response codes
`define MPMB_CC_OK 8'h00
`define MPMB_CC_ILLEGAL_DATA 8'h03
`define MPMB_CC_ILLEGAL_SUB 8'h04
`define MPMB_CC_LOCKED 8'h06
`define MPMB_CC_OVERRIDE 8'h11

// Restriction answers
`define MPMB_RS_SAFE 2'h0
`define MPMB_RS_NOT_SAFE 2'h1
`define MPMB_RS_REJECT 2'h2

// Legacy answers and selections
`define MPMB_LG_NOT_SAFE 2'h0
`define MPMB_LG_SAFE 2'h1
`define MPMB_LG_DISABLE 3'h0
`define MPMB_LG_ENABLE 3'h3

// Point table word layout
`define MPMB_TW_CLK_HI 15
`define MPMB_TW_CLK_LO 0
`define MPMB_TW_TRP_LO 16
`define MPMB_TW_TRCD_LO 24
`define MPMB_TW_TRDPRE_LO 32
`define MPMB_TW_TRAS_HI 48
`define MPMB_TW_TRAS_LO 40
`define MPMB_TW_WIDTH 49

// Timing
`define MPMB_CLK_MHZ 20
`define MPMB_SETTLE_US 100
`define MPMB_MOVE_LIMIT_US 1000
`define MPMB_SETTLE_CYC (`MPMB_SETTLE_US * `MPMB_CLK_MHZ)
`define MPMB_MOVE_LIMIT_CYC (`MPMB_MOVE_LIMIT_US * `MPMB_CLK_MHZ)

`endif

//--- logic/mpmb_pkg.sv
// Types shared by the memory point mailbox files.
// Assumes mpmb_regs.svh supplies the numeric constants.
package mpmb_pkg;

    typedef enum logic [2:0] {
        MPMB_IDLE = 3'b000,
        MPMB_EXEC = 3'b001,
        MPMB_RD_ADDR = 3'b010,
        MPMB_RD_ACC = 3'b011,
        MPMB_RESP = 3'b100
    } mpmb_state_e;

    typedef enum logic [3:0] {
        MPMB_DDR4 = 4'h0,
        MPMB_DDR5 = 4'h1,
        MPMB_LPDDR5 = 4'h2,
        MPMB_LPDDR4 = 4'h3,
        MPMB_DDR3 = 4'h4,
        MPMB_LPDDR3 = 4'h5
    } mpmb_mem_type_e;

    typedef logic [63:0] mpmb_payload_t;

endpackage : mpmb_pkg

//--- logic/mpmb_tbl_if.sv
// Link between the mailbox sequencer and its point timing table.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface mpmb_tbl_if #(
    parameter int ADDR_W = 5,
    parameter int DATA_W = 49
);
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;

    modport host (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : mpmb_tbl_if

//--- logic/mpmb_tbl.sv
// Point timing table: one word per point and channel, read data registered.
// Assumes addresses are {point, channel}; contents are undefined until loaded.
`timescale 1ns/1ps
module mpmb_tbl #(
    parameter int DEPTH = 32
) (
    // Clock
    input wire logic ref_clk,
    // Table access
    mpmb_tbl_if.mem tbl
);
    logic [$bits(tbl.wr_data)-1:0] mem_q [DEPTH];
    logic [$bits(tbl.rd_data)-1:0] rd_q;

    always_ff @(posedge ref_clk) begin
        if (tbl.wr_en) begin
            mem_q[tbl.wr_addr] <= tbl.wr_data;
        end
        rd_q <= mem_q[tbl.rd_addr];
    end

    assign tbl.rd_data = rd_q;
endmodule : mpmb_tbl

//--- logic/mpmb_mailbox.sv
// Memory point mailbox: info queries, point restriction and legacy hold.
// Assumes a synchronous register port and configuration straps from the memory side.
//
// How it works
// - Subcommand comes from first_parameter bits 15:8
// - Global info: type, channels, point count
// - Memory type codes 0 to 5
// - Point index beyond count gives illegal data
// - Point info: clock then four timing fields, the last (tRAS) nine bits wide
// - Timings are maximum across the populated channels given by cfg_chan_count
// - Restriction mask bits 7:0 forbid points
// - Restriction answer: safe, not safe, rejected
// - Response codes 00h, 03h, 04h, 06h, 11h
// - Ack fast, move finished within 1ms
// - Leave forbidden point, then report safe
// - Mask starts clear, cleared by function reset
// - Firmware point request overrides display mask
// - Legacy 0 holds highest point, 3 releases
// - Legacy answer: 0 not safe, 1 safe
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "mpmb_regs.svh"
module mpmb_mailbox #(
    parameter int POINTS = 8,
    parameter int CHANNELS = 4,
    parameter int SETTLE_CYC = `MPMB_SETTLE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Memory configuration
    input wire mpmb_pkg::mpmb_mem_type_e cfg_mem_type,
    input wire logic [3:0] cfg_chan_count,
    input wire logic [3:0] cfg_point_count,
    input wire logic cfg_locked,
    // Point table load
    input wire logic tbl_wr,
    input wire logic [$clog2(POINTS*CHANNELS)-1:0] tbl_addr,
    input wire logic [`MPMB_TW_WIDTH-1:0] tbl_wdata,
    // Firmware point request and function reset
    input wire logic fw_override,
    input wire logic [7:0] fw_allowed,
    input wire logic flr_pulse,
    // Point control
    output logic [2:0] point_sel,
    output logic point_moving
);
    import mpmb_pkg::*;

    localparam int CW = $clog2(CHANNELS);
    localparam int AW = $clog2(POINTS*CHANNELS);

    // Refused at elaboration: the mask is one byte and the channel count a nibble
    if (POINTS != 8 || CHANNELS < 2 || CHANNELS > 8 || (CHANNELS & (CHANNELS - 1)) != 0) begin : g_bad_size
        $error("mpmb_mailbox: POINTS must be 8, CHANNELS a power of two from 2 to 8");
    end
    if (SETTLE_CYC < 1 || SETTLE_CYC > `MPMB_MOVE_LIMIT_CYC || SETTLE_CYC > 65535) begin : g_bad_settle
        $error("mpmb_mailbox: SETTLE_CYC must lie between 1 and the move limit");
    end

    // Highest set bit of a point mask
    function automatic logic [2:0] top_point(input logic [7:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : top_point

    // Points allowed under a display mask, hold flag and firmware request
    function automatic logic [7:0] allowed_of(input logic [7:0] dmask, input logic hold,
                                              input logic [7:0] en, input logic fw,
                                              input logic [7:0] fwm);
        logic [7:0] a;
        a = fw ? (fwm & en) : (~dmask & en);
        if (hold && !fw) begin
            a = 8'h01 << top_point(en);
        end
        return a;
    endfunction : allowed_of

    // Maximum of two timing words, field by field
    function automatic logic [`MPMB_TW_WIDTH-1:0] tw_max(input logic [`MPMB_TW_WIDTH-1:0] a,
                                                        input logic [`MPMB_TW_WIDTH-1:0] b);
        logic [`MPMB_TW_WIDTH-1:0] r;
        r = a;
        if (b[15:0] > a[15:0]) r[15:0] = b[15:0];
        for (int f = 0; f < 3; f++) begin
            if (b[16+8*f +: 8] > a[16+8*f +: 8]) r[16+8*f +: 8] = b[16+8*f +: 8];
        end
        if (b[48:40] > a[48:40]) r[48:40] = b[48:40];
        return r;
    endfunction : tw_max

    mpmb_tbl_if #(.ADDR_W(AW), .DATA_W(`MPMB_TW_WIDTH)) tbl_bus ();

    mpmb_tbl #(.DEPTH(POINTS*CHANNELS)) u_tbl (
        .ref_clk(ref_clk),
        .tbl(tbl_bus.mem)
    );

    mpmb_state_e state_q, state_d;
    logic busy_q, busy_d;
    logic [7:0] cmd_q, cmd_d;
    logic [7:0] p1_q, p1_d;
    logic [7:0] p2_q, p2_d;
    mpmb_payload_t pay_q, pay_d;
    logic [7:0] dmask_q, dmask_d;
    logic hold_q, hold_d;
    logic [2:0] cur_q, cur_d;
    logic [2:0] tgt_q, tgt_d;
    logic moving_q, moving_d;
    logic [15:0] tmr_q, tmr_d;
    logic [CW-1:0] ch_q, ch_d;
    logic [`MPMB_TW_WIDTH-1:0] acc_q, acc_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] enabled;
    logic [7:0] allowed;
    logic [7:0] allowed_new;
    logic [CW-1:0] last_ch;
    logic [3:0] nch;

    always_comb begin
        enabled = 8'h00;
        for (int i = 0; i < 8; i++) begin
            enabled[i] = (4'(i) < cfg_point_count);
        end
        nch = (cfg_chan_count == 4'h0) ? 4'h1 : ((cfg_chan_count > 4'(CHANNELS)) ? 4'(CHANNELS) : cfg_chan_count);
        last_ch = CW'(nch - 4'h1);
        allowed = allowed_of(dmask_q, hold_q, enabled, fw_override, fw_allowed);
    end

    assign tbl_bus.wr_en = tbl_wr;
    assign tbl_bus.wr_addr = tbl_addr;
    assign tbl_bus.wr_data = tbl_wdata;
    assign tbl_bus.rd_addr = {p2_q[2:0], ch_q};

    always_comb begin
        state_d = state_q;
        busy_d = busy_q;
        cmd_d = cmd_q;
        p1_d = p1_q;
        p2_d = p2_q;
        pay_d = pay_q;
        dmask_d = dmask_q;
        hold_d = hold_q;
        cur_d = cur_q;
        tgt_d = tgt_q;
        moving_d = moving_q;
        tmr_d = tmr_q;
        ch_d = ch_q;
        acc_d = acc_q;
        rdata_d = 32'h0;
        allowed_new = allowed;

        // Register port; payload and command are owned by the block while busy
        if (reg_rd) begin
            case (reg_addr)
                `MPMB_OFF_IFACE: rdata_d = {busy_q, 7'h0, p2_q, p1_q, cmd_q};
                `MPMB_OFF_LOW: rdata_d = pay_q[31:0];
                `MPMB_OFF_HIGH: rdata_d = pay_q[63:32];
                `MPMB_OFF_POINT: rdata_d = {16'h0, allowed, 3'h0, moving_q, 1'b0, cur_q};
                default: rdata_d = 32'h0;
            endcase
        end
        if (reg_wr && !busy_q) begin
            case (reg_addr)
                `MPMB_OFF_LOW: pay_d[31:0] = reg_wdata;
                `MPMB_OFF_HIGH: pay_d[63:32] = reg_wdata;
                `MPMB_OFF_IFACE: begin
                    cmd_d = reg_wdata[`MPMB_IF_CMD_HI:`MPMB_IF_CMD_LO];
                    p1_d = reg_wdata[`MPMB_IF_P1_HI:`MPMB_IF_P1_LO];
                    p2_d = reg_wdata[`MPMB_IF_P2_HI:`MPMB_IF_P2_LO];
                    if (reg_wdata[`MPMB_IF_BUSY]) begin
                        busy_d = 1'b1;
                        state_d = MPMB_EXEC;
                    end
                end
                default: ;
            endcase
        end

        // Mailbox sequencer; every answer has payload and code in place at least one cycle before busy clears
        case (state_q)
            MPMB_IDLE: ;
            MPMB_EXEC: begin
                state_d = MPMB_RESP;
                pay_d = 64'h0;
                cmd_d = `MPMB_CC_OK;
                case (cmd_q)
                    `MPMB_CMD_INFO: begin
                        if (p1_q == `MPMB_SUB_GLOBAL) begin
                            pay_d[11:0] = {cfg_point_count, cfg_chan_count, 4'(cfg_mem_type)};
                        end else if (p1_q == `MPMB_SUB_POINT) begin
                            if ({4'h0, p2_q[7:4]} != 8'h0 || p2_q[3:0] >= cfg_point_count) begin
                                cmd_d = `MPMB_CC_ILLEGAL_DATA;
                            end else begin
                                ch_d = '0;
                                acc_d = '0;
                                state_d = MPMB_RD_ADDR;
                            end
                        end else begin
                            cmd_d = `MPMB_CC_ILLEGAL_SUB;
                        end
                    end
                    `MPMB_CMD_RESTRICT: begin
                        if (cfg_locked) begin
                            cmd_d = `MPMB_CC_LOCKED;
                        end else if (pay_q[63:8] != 56'h0 || (~pay_q[7:0] & enabled) == 8'h00) begin
                            cmd_d = `MPMB_CC_ILLEGAL_DATA;
                        end else if (fw_override) begin
                            cmd_d = `MPMB_CC_OVERRIDE;
                            pay_d[1:0] = `MPMB_RS_REJECT;
                        end else begin
                            dmask_d = pay_q[7:0];
                            allowed_new = allowed_of(pay_q[7:0], hold_q, enabled, 1'b0, fw_allowed);
                            pay_d[1:0] = (allowed_new[cur_q] && !moving_q) ? `MPMB_RS_SAFE : `MPMB_RS_NOT_SAFE;
                        end
                    end
                    `MPMB_CMD_LEGACY: begin
                        if (cfg_locked) begin
                            cmd_d = `MPMB_CC_LOCKED;
                        end else if (pay_q[63:3] != 61'h0 ||
                                     (pay_q[2:0] != `MPMB_LG_DISABLE && pay_q[2:0] != `MPMB_LG_ENABLE)) begin
                            cmd_d = `MPMB_CC_ILLEGAL_DATA;
                        end else begin
                            hold_d = (pay_q[2:0] == `MPMB_LG_DISABLE);
                            allowed_new = allowed_of(dmask_q, hold_d, enabled, fw_override, fw_allowed);
                            pay_d[1:0] = (allowed_new[cur_q] && !moving_q) ? `MPMB_LG_SAFE : `MPMB_LG_NOT_SAFE;
                        end
                    end
                    default: cmd_d = `MPMB_CC_ILLEGAL_SUB;
                endcase
            end
            MPMB_RD_ADDR: state_d = MPMB_RD_ACC;
            MPMB_RD_ACC: begin
                acc_d = tw_max(acc_q, tbl_bus.rd_data);
                if (ch_q == last_ch) begin
                    pay_d = 64'({acc_d});
                    state_d = MPMB_RESP;
                end else begin
                    ch_d = ch_q + CW'(1);
                    state_d = MPMB_RD_ADDR;
                end
            end
            MPMB_RESP: begin
                busy_d = 1'b0;
                state_d = MPMB_IDLE;
            end
            default: state_d = MPMB_IDLE;
        endcase

        // A function reset drops the display mask and legacy hold
        if (flr_pulse) begin
            dmask_d = 8'h00;
            hold_d = 1'b0;
        end

        // Point mover; settle time stands for the memory transition, well under the limit
        if (moving_q) begin
            if (tmr_q == 16'h0) begin
                cur_d = tgt_q;
                moving_d = 1'b0;
            end else begin
                tmr_d = tmr_q - 16'h1;
            end
        end else if (!allowed[cur_q] && allowed != 8'h00) begin
            tgt_d = top_point(allowed);
            moving_d = 1'b1;
            tmr_d = 16'(SETTLE_CYC - 1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= MPMB_IDLE;
            busy_q <= 1'b0;
            cmd_q <= 8'h00;
            p1_q <= 8'h00;
            p2_q <= 8'h00;
            pay_q <= 64'h0;
            dmask_q <= 8'h00;
            hold_q <= 1'b0;
            cur_q <= 3'h0;
            tgt_q <= 3'h0;
            moving_q <= 1'b0;
            tmr_q <= 16'h0;
            ch_q <= '0;
            acc_q <= '0;
            rdata_q <= 32'h0;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            cmd_q <= cmd_d;
            p1_q <= p1_d;
            p2_q <= p2_d;
            pay_q <= pay_d;
            dmask_q <= dmask_d;
            hold_q <= hold_d;
            cur_q <= cur_d;
            tgt_q <= tgt_d;
            moving_q <= moving_d;
            tmr_q <= tmr_d;
            ch_q <= ch_d;
            acc_q <= acc_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign point_sel = cur_q;
    assign point_moving = moving_q;
endmodule : mpmb_mailbox

//--- sim/mpmb_mailbox_asserts.sv
// Checker on the mailbox top ports.
// Assumes one clock, synchronous reset and the bench's short settle count.
`timescale 1ns/1ps
module mpmb_mailbox_chk #(
    parameter int SETTLE_CYC = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Configuration and control
    input wire logic [3:0] cfg_point_count,
    input wire logic fw_override,
    input wire logic flr_pulse,
    input wire logic [2:0] point_sel,
    input wire logic point_moving
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic st_rd;
    logic [7:0] en_m;
    logic [15:0] mv_cnt_q;
    assign st_rd = reg_rd && reg_addr == 8'h0c;
    // Counts of eight or more enable every point
    assign en_m = 8'((9'h001 << cfg_point_count) - 9'h001);

    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
    property p_busy_seen;
        reg_wr && reg_addr == 8'h00 && reg_wdata[31] ##1 reg_rd && reg_addr == 8'h00 |=> reg_rdata[31];
    endproperty
    a_busy_seen: assert property (p_busy_seen) else $error("busy not set after command");
    property p_sel_moves;
        $changed(point_sel) |-> $past(point_moving) || $past(point_moving, 2);
    endproperty
    a_sel_moves: assert property (p_sel_moves) else $error("point changed without move");
    property p_move_end;
        $rose(point_moving) |-> ##[1:1000] !point_moving;
    endproperty
    a_move_end: assert property (p_move_end) else $error("move too long");
    // Three cycles is the floor for any settle count the bench uses
    property p_move_hold;
        $rose(point_moving) |-> (point_moving && $stable(point_sel)) [*3];
    endproperty
    a_move_hold: assert property (p_move_hold) else $error("move cut short");
    // Counts the cycles a move stands, so its length is checked for any settle count
    always_ff @(posedge ref_clk) begin
        mv_cnt_q <= (reset || !point_moving) ? 16'h0 : mv_cnt_q + 16'h1;
    end
    property p_move_len;
        $fell(point_moving) |-> mv_cnt_q == 16'(SETTLE_CYC);
    endproperty
    a_move_len: assert property (p_move_len) else $error("move length wrong");
    property p_status;
        st_rd |=> reg_rdata[2:0] == $past(point_sel) && reg_rdata[4] == $past(point_moving);
    endproperty
    a_status: assert property (p_status) else $error("status mismatch");
    property p_enabled;
        st_rd |=> (reg_rdata[15:8] >> $past(cfg_point_count)) == 8'h00;
    endproperty
    a_enabled: assert property (p_enabled) else $error("disabled point allowed");
    property p_flr;
        flr_pulse ##1 (st_rd && !fw_override) |=> reg_rdata[15:8] == $past(en_m);
    endproperty
    a_flr: assert property (p_flr) else $error("mask kept after function reset");
    property p_reset_out;
        $fell(reset) |-> point_sel == 3'h0 && !point_moving && reg_rdata == 32'h0;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");

    c_move: cover property ($rose(point_moving));
    c_flr: cover property (flr_pulse ##1 st_rd);
    c_cmd: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata[31]);
endmodule : mpmb_mailbox_chk

bind mpmb_mailbox mpmb_mailbox_chk #(.SETTLE_CYC(SETTLE_CYC)) chk (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg_point_count(cfg_point_count), .fw_override(fw_override),
    .flr_pulse(flr_pulse), .point_sel(point_sel), .point_moving(point_moving)
);

//--- sim/mpmb_mailbox_test.sv
// Self-checking bench for the memory point mailbox.
// Assumes the designer's register map and a settle count of four cycles.
`timescale 1ns/1ps
module mpmb_mailbox_test;
    import mpmb_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    mpmb_mem_type_e cfg_mem_type = MPMB_DDR4;
    logic [3:0] cfg_chan_count = 4'h2;
    logic [3:0] cfg_point_count = 4'h4;
    logic cfg_locked = 1'b0;
    logic tbl_wr = 1'b0;
    logic [4:0] tbl_addr = 5'h00;
    logic [48:0] tbl_wdata = 49'h0;
    logic fw_override = 1'b0;
    logic [7:0] fw_allowed = 8'h00;
    logic flr_pulse = 1'b0;
    logic [2:0] point_sel;
    logic point_moving;
    int fails = 0;
    int n_checks = 0;
    logic [7:0] cc;
    logic [63:0] r;
    logic [31:0] v;

    always #25 ref_clk = ~ref_clk;

    mpmb_mailbox #(.SETTLE_CYC(4)) dut (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_mem_type(cfg_mem_type),
        .cfg_chan_count(cfg_chan_count), .cfg_point_count(cfg_point_count), .cfg_locked(cfg_locked),
        .tbl_wr(tbl_wr), .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .fw_override(fw_override),
        .fw_allowed(fw_allowed), .flr_pulse(flr_pulse), .point_sel(point_sel), .point_moving(point_moving)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Write strobe stays up for back-to-back writes; the next read drops it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_wr <= 1'b0;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask : rd

    task automatic mbx(input logic [63:0] pl, input logic [7:0] cmd, input logic [7:0] p1, input logic [7:0] p2);
        int i;
        wr(8'h04, pl[31:0]);
        wr(8'h08, pl[63:32]);
        wr(8'h00, {1'b1, 7'h00, p2, p1, cmd});
        v = 32'hffff_ffff;
        for (i = 0; i < 40 && v[31] !== 1'b0; i++)
            rd(8'h00, v);
        chk(v & 32'h8000_0000, 32'h0);
        cc = v[7:0];
        rd(8'h04, r[31:0]);
        rd(8'h08, r[63:32]);
    endtask : mbx

    task automatic until_safe(input logic [7:0] cmd, input logic [63:0] pl, input logic [1:0] safe);
        int i;
        mbx(pl, cmd, 8'h00, 8'h00);
        for (i = 0; i < 12 && r[1:0] !== safe; i++)
            mbx(pl, cmd, 8'h00, 8'h00);
        chk({cc, 22'h0, r[1:0]}, {8'h00, 22'h0, safe});
    endtask : until_safe

    task automatic tw(input logic [4:0] a, input logic [48:0] d);
        tbl_addr <= a;
        tbl_wdata <= d;
        tbl_wr <= 1'b1;
        @(posedge ref_clk);
    endtask : tw

    task automatic t_reset;
        rd(8'h0c, v);
        chk(v, 32'h0000_0f00);
    endtask : t_reset

    task automatic t_global;
        int t;
        for (t = 0; t < 6; t++) begin
            cfg_mem_type <= mpmb_mem_type_e'(t);
            mbx(64'h0, 8'h0d, 8'h00, 8'h00);
            chk({cc, r[23:0]}, {8'h00, 12'h000, 4'h4, 4'h2, 4'(t)});
        end
        mbx(64'h0, 8'h0d, 8'h02, 8'h00);
        chk({24'h0, cc}, 32'h04);
        mbx(64'h0, 8'h55, 8'h00, 8'h00);
        chk({24'h0, cc}, 32'h04);
    endtask : t_global

    task automatic t_point;
        tw(5'h04, {9'h0a0, 8'h20, 8'h05, 8'h10, 16'h0030});
        tw(5'h05, {9'h120, 8'h1c, 8'h09, 8'h0c, 16'h0028});
        // Channel two is unpopulated, so its large values must not win
        tw(5'h06, {9'h1ff, 8'hff, 8'hff, 8'hff, 16'hffff});
        tbl_wr <= 1'b0;
        mbx(64'h0, 8'h0d, 8'h01, 8'h01);
        chk(r[31:0], 32'h0910_0030);
        chk({cc, r[55:32]}, 32'h0001_2020);
        mbx(64'h0, 8'h0d, 8'h01, 8'h04);
        chk({24'h0, cc}, 32'h03);
        mbx(64'h0, 8'h0d, 8'h01, 8'h03);
        chk({24'h0, cc}, 32'h00);
    endtask : t_point

    task automatic t_legacy;
        mbx(64'h1, 8'h21, 8'h00, 8'h00);
        chk({24'h0, cc}, 32'h03);
        mbx(64'h0, 8'h21, 8'h00, 8'h00);
        chk({cc, r[23:0]}, 32'h0);
        until_safe(8'h21, 64'h0, 2'h1);
        chk({29'h0, point_sel}, 32'h3);
        until_safe(8'h21, 64'h3, 2'h1);
    endtask : t_legacy

    task automatic t_restrict;
        mbx(64'h08, 8'h0e, 8'h00, 8'h00);
        chk({cc, r[23:0]}, 32'h1);
        until_safe(8'h0e, 64'h08, 2'h0);
        chk({29'h0, point_sel}, 32'h2);
        mbx(64'h0f, 8'h0e, 8'h00, 8'h00);
        chk({24'h0, cc}, 32'h03);
        mbx(64'h108, 8'h0e, 8'h00, 8'h00);
        chk({24'h0, cc}, 32'h03);
        rd(8'h0c, v);
        chk(v, 32'h0000_0702);
    endtask : t_restrict

    task automatic t_errs;
        cfg_locked <= 1'b1;
        mbx(64'h08, 8'h0e, 8'h00, 8'h00);
        chk({24'h0, cc}, 32'h06);
        mbx(64'h0, 8'h21, 8'h00, 8'h00);
        chk({24'h0, cc}, 32'h06);
        cfg_locked <= 1'b0;
        fw_override <= 1'b1;
        fw_allowed <= 8'h04;
        mbx(64'h08, 8'h0e, 8'h00, 8'h00);
        chk({cc, r[23:0]}, 32'h1100_0002);
        fw_override <= 1'b0;
    endtask : t_errs

    task automatic t_flr;
        flr_pulse <= 1'b1;
        @(posedge ref_clk);
        flr_pulse <= 1'b0;
        rd(8'h0c, v);
        chk(v, 32'h0000_0f02);
    endtask : t_flr

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_reset;
        t_global;
        t_point;
        t_legacy;
        t_restrict;
        t_errs;
        t_flr;
        wrap_up;
    end

    // The tests need a few hundred cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        wrap_up;
    end
endmodule : mpmb_mailbox_test
